//--- core/wsc_pkg.sv
// Package for the wiper shortcut command unit: widths, command codes, timing.
// Assumes a 125 MHz core clock and a separate link-side command clock.
package wsc_pkg;
  localparam int W9 = 9;
  localparam int W7 = 7;
  localparam logic [8:0] FULL9 = 9'h1FF;
  localparam logic [8:0] MID9 = 9'h100;
  localparam logic [6:0] FULL7 = 7'h7F;
  localparam logic [6:0] MID7 = 7'h40;
  localparam logic [8:0] RST9 = 9'h100;
  localparam logic [6:0] RST7 = 7'h40;
  localparam int CLK_MHZ = 125;
  localparam int STORE_MS = 25;
  localparam int STORE_CYC = STORE_MS * 1000 * CLK_MHZ;
  localparam int NV_READ_CYC = 2;
  localparam logic [4:0] SLV_ADDR_TOP = 5'h0A;
  localparam logic [4:0] MEM_ADDR_TOP = 5'h14;

  typedef enum logic [3:0] {
    WSC_NOP = 4'h0,
    WSC_RESTORE_ONE = 4'h1,
    WSC_STORE_ONE = 4'h2,
    WSC_DEC6_ONE = 4'h3,
    WSC_DEC6_ALL = 4'h4,
    WSC_DEC1_ONE = 4'h5,
    WSC_DEC1_ALL = 4'h6,
    WSC_RESTORE_ALL = 4'h7,
    WSC_INC6_ONE = 4'h8,
    WSC_INC6_ALL = 4'h9,
    WSC_INC1_ONE = 4'hA,
    WSC_INC1_ALL = 4'hB
  } wsc_cmd_e;

  typedef struct packed {
    logic cmd_select;
    logic [3:0] code;
    logic [1:0] chan;
  } wsc_cmd_s;

  typedef struct packed {
    logic [8:0] w0;
    logic [8:0] w1;
    logic [6:0] w2;
  } wsc_wipers_s;
endpackage : wsc_pkg

//--- core/wsc_unit.sv
// Shortcut command interpreter for three wiper registers with nonvolatile copy.
// Commands arrive from bus logic on LCLK; execution runs on MCLK.
`timescale 1ns/1ps
module wsc_unit
  import wsc_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYC
) (
  input wire logic MCLK, // Core clock
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic LCLK, // Link-side command clock
  input wire logic LRST_N, // Link-side reset, active low
  input wire logic CMD_VALID, // Command strobe on LCLK
  input wire wsc_pkg::wsc_cmd_s CMD, // Command fields on LCLK
  output logic CMD_READY, // Link may send a command
  input wire logic WP_N_PIN, // Write protect pin, low protects
  input wire logic WP_PULL_N, // Low when pin undriven (pull-down)
  input wire logic MEM_ADDR_HI_PIN, // memory_bus_addr_high_pin
  input wire logic MEM_ADDR_LO_PIN, // memory_bus_addr_low_pin
  input wire logic SLV_SEL_HI_PIN, // slave_select_pin_high
  input wire logic SLV_SEL_LO_PIN, // slave_select_pin_low
  output logic [6:0] SLAVE_ADDR, // Wiper slave bus address
  output logic [6:0] MEM_ADDR, // Nonvolatile store bus address
  output logic BUSY, // Bus must not acknowledge
  output logic NV_READ_STATE, // Nonvolatile-read power state
  output wsc_pkg::wsc_wipers_s WIPER, // wiper_register values
  output logic [511:0] TAP0, // One-hot tap switches channel 0
  output logic [511:0] TAP1, // One-hot tap switches channel 1
  output logic [127:0] TAP2, // One-hot tap switches channel 2
  output logic BOTTOM_SW // bottom_terminal_switch
);
  // ==================================================================
  // Link side: toggle handshake carries one command at a time
  wsc_cmd_s l_cmd;
  logic l_req, l_ack_s1, l_ack_s2;
  logic m_req_s1, m_req_s2, m_req_d, m_ack;
  wsc_cmd_s m_cmd;

  assign CMD_READY = (l_req == l_ack_s2);

  always_ff @(posedge LCLK) begin
    if (!LRST_N) begin
      l_req <= 1'b0;
      l_cmd <= '0;
    end else if (CMD_VALID && CMD_READY) begin
      l_req <= ~l_req;
      l_cmd <= CMD;
    end
  end

  always_ff @(posedge LCLK) begin
    if (!LRST_N) begin
      l_ack_s1 <= 1'b0;
      l_ack_s2 <= 1'b0;
    end else begin
      l_ack_s1 <= m_ack;
      l_ack_s2 <= l_ack_s1;
    end
  end

  // ==================================================================
  // Core side synchronisers
  logic wp_s1, wp_s2, pull_s1, pull_s2;
  logic [3:0] pin_s1, pin_s2;
  // Request toggle from LCLK; m_req_d keeps the last value seen
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      m_req_s1 <= 1'b0;
      m_req_s2 <= 1'b0;
      m_req_d <= 1'b0;
    end else begin
      m_req_s1 <= l_req;
      m_req_s2 <= m_req_s1;
      m_req_d <= m_req_s2;
    end
  end

  // Protect pin and its undriven sense, both asynchronous
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
      pull_s1 <= 1'b0;
      pull_s2 <= 1'b0;
    end else begin
      wp_s1 <= WP_N_PIN;
      wp_s2 <= wp_s1;
      pull_s1 <= WP_PULL_N;
      pull_s2 <= pull_s1;
    end
  end

  // Address strap pins
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= {MEM_ADDR_HI_PIN, MEM_ADDR_LO_PIN, SLV_SEL_HI_PIN, SLV_SEL_LO_PIN};
      pin_s2 <= pin_s1;
    end
  end

  // Undriven pin pulls low: protected by default
  logic protect;
  assign protect = !wp_s2 || !pull_s2;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SLAVE_ADDR <= 7'h00;
    end else begin
      SLAVE_ADDR <= {SLV_ADDR_TOP, pin_s2[1], pin_s2[0]};
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      MEM_ADDR <= 7'h00;
    end else begin
      MEM_ADDR <= {MEM_ADDR_TOP, pin_s2[3], pin_s2[2]};
    end
  end

  // ==================================================================
  // Wiper arithmetic
  function automatic logic [8:0] shl9(input logic [8:0] v, input logic [8:0] mid,
                                      input logic [8:0] full);
    if (v == 9'h000) shl9 = 9'h001;
    else if (v >= mid) shl9 = full;
    else shl9 = {v[7:0], 1'b0};
  endfunction : shl9

  function automatic logic [8:0] step9(input logic [8:0] v, input logic up,
                                       input logic [8:0] full);
    if (up) step9 = (v == full) ? v : v + 9'h001;
    else step9 = (v == 9'h000) ? v : v - 9'h001;
  endfunction : step9

  function automatic logic [8:0] apply(input logic [3:0] c, input logic [8:0] v,
                                       input logic [8:0] nv, input logic [8:0] mid,
                                       input logic [8:0] full);
    case (c)
      WSC_RESTORE_ONE, WSC_RESTORE_ALL: apply = nv;
      WSC_DEC6_ONE, WSC_DEC6_ALL: apply = {1'b0, v[8:1]};
      WSC_INC6_ONE, WSC_INC6_ALL: apply = shl9(v, mid, full);
      WSC_DEC1_ONE, WSC_DEC1_ALL: apply = step9(v, 1'b0, full);
      WSC_INC1_ONE, WSC_INC1_ALL: apply = step9(v, 1'b1, full);
      default: apply = v;
    endcase
  endfunction : apply

  // ==================================================================
  // Command execution
  typedef enum logic [1:0] {
    WSC_IDLE = 2'b00,
    WSC_NVREAD = 2'b01,
    WSC_WRITE = 2'b10,
    WSC_DONE = 2'b11
  } wsc_state_e;

  wsc_state_e state;
  logic [8:0] wr0, wr1, nv0, nv1;
  logic [6:0] wr2, nv2;
  logic [31:0] cnt;
  logic m_new;
  logic [3:0] code;
  logic all_ch, is_all, is_store;
  assign m_new = m_req_s2 ^ m_req_d;
  assign code = m_cmd.code;
  assign is_all = (code == WSC_DEC6_ALL) || (code == WSC_DEC1_ALL) || (code == WSC_RESTORE_ALL)
    || (code == WSC_INC6_ALL) || (code == WSC_INC1_ALL);
  assign is_store = (code == WSC_STORE_ONE);
  assign all_ch = is_all;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      m_cmd <= '0;
    end else if (m_new) begin
      m_cmd <= l_cmd;
    end
  end

  logic go;
  always_ff @(posedge MCLK) begin
    if (!RST_N) go <= 1'b0;
    else go <= m_new;
  end

  logic [8:0] nx2;
  assign nx2 = apply(code, {2'b00, wr2}, {2'b00, nv2}, {2'b00, MID7}, {2'b00, FULL7});

  // Wiper moves at the go edge, the same edge that starts a plain command's ack back to LCLK
  // Single-channel commands use the channel field; code 0 and 12-15 do nothing
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wr0 <= RST9;
      wr1 <= RST9;
      wr2 <= RST7;
    end else if (go && m_cmd.cmd_select && code <= 4'hB && !is_store) begin
      if (all_ch || m_cmd.chan == 2'd0) wr0 <= apply(code, wr0, nv0, MID9, FULL9);
      if (all_ch || m_cmd.chan == 2'd1) wr1 <= apply(code, wr1, nv1, MID9, FULL9);
      if (all_ch || m_cmd.chan == 2'd2) wr2 <= nx2[6:0];
    end
  end

  // Nonvolatile copies; writes only when unprotected
  // Restore-all runs the same timer, so only a store may write
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      nv0 <= RST9;
      nv1 <= RST9;
      nv2 <= RST7;
    end else if (state == WSC_WRITE && cnt == 32'd1 && is_store && !protect) begin
      if (m_cmd.chan == 2'd0) nv0 <= wr0;
      if (m_cmd.chan == 2'd1) nv1 <= wr1;
      if (m_cmd.chan == 2'd2) nv2 <= wr2;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= WSC_IDLE;
      cnt <= 32'd0;
      m_ack <= 1'b0;
    end else begin
      case (state)
        WSC_IDLE, WSC_NVREAD: begin
          if (go) begin
            if (!m_cmd.cmd_select) begin
              m_ack <= m_req_d;
            end else if (code == WSC_NOP) begin
              state <= WSC_IDLE;
              m_ack <= m_req_d;
            end else if (code == WSC_RESTORE_ONE) begin
              state <= WSC_NVREAD;
              m_ack <= m_req_d;
            end else if (is_store) begin
              state <= WSC_WRITE;
              cnt <= STORE_CYCLES;
            end else if (code == WSC_RESTORE_ALL) begin
              state <= WSC_WRITE;
              cnt <= NV_READ_CYC;
            end else begin
              m_ack <= m_req_d;
            end
          end
        end
        WSC_WRITE: begin
          if (cnt <= 32'd1) state <= WSC_DONE;
          else cnt <= cnt - 32'd1;
        end
        WSC_DONE: begin
          state <= WSC_IDLE;
          m_ack <= m_req_d;
        end
        default: state <= WSC_IDLE;
      endcase
    end
  end

  // Busy while a command is queued or a timed operation runs
  assign BUSY = (state == WSC_WRITE) || (state == WSC_DONE) || m_new || go;
  assign NV_READ_STATE = (state == WSC_NVREAD);
  assign WIPER = '{w0: wr0, w1: wr1, w2: wr2};

  // ==================================================================
  // Tap decode: exactly one switch closed per channel once out of reset, none in reset
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      TAP0 <= '0;
      TAP1 <= '0;
      TAP2 <= '0;
    end else begin
      TAP0 <= 512'h1 << wr0;
      TAP1 <= 512'h1 << wr1;
      TAP2 <= 128'h1 << wr2;
    end
  end
  assign BOTTOM_SW = 1'b1;
endmodule : wsc_unit

//--- testbench/wsc_master_model.sv
// Link-side command source standing in for the bus master.
// Assumes CMD_READY and BUSY of wsc_unit; one command in flight.
`timescale 1ns/1ps
module wsc_master_model
  import wsc_pkg::*;
(
  input wire logic LCLK, // Link clock
  input wire logic CMD_READY, // Unit takes command
  input wire logic BUSY, // Bus held off
  output logic CMD_VALID, // Command offered
  output wsc_pkg::wsc_cmd_s CMD // Command fields
);
  wsc_cmd_s held = '0;
  wsc_cmd_s pat = '0;
  int stalls = 0;
  initial CMD_VALID = 1'b0;
  // Idle lines toggle so a late sample never sees the old command
  always @(posedge LCLK) pat <= ~pat;
  assign CMD = CMD_VALID ? held : pat;
  task automatic issue(input wsc_cmd_s c);
    int n;
    for (n = 0; n < 4000 && CMD_READY !== 1'b1; n++) @(posedge LCLK);
    if (n >= 4000) stalls++;
    @(posedge LCLK);
    held <= c;
    CMD_VALID <= 1'b1;
    // Offer stands until the unit is seen ready at an edge
    @(posedge LCLK);
    for (n = 0; n < 4000 && CMD_READY !== 1'b1; n++) @(posedge LCLK);
    if (n >= 4000) stalls++;
    CMD_VALID <= 1'b0;
    @(posedge LCLK);
    for (n = 0; n < 4000 && (CMD_READY !== 1'b1 || BUSY !== 1'b0); n++) @(posedge LCLK);
    if (n >= 4000) stalls++;
  endtask : issue
endmodule : wsc_master_model

//--- testbench/wsc_unit_props.sv
// Port checker for wsc_unit: decode, pin addresses, busy and state timing.
// Assumes it is bound to wsc_unit and sees only its ports.
`timescale 1ns/1ps
module wsc_unit_chk
  import wsc_pkg::*;
#(
  parameter int STORE_CYCLES = 20
) (
  input wire logic MCLK, // Core clock
  input wire logic RST_N, // Sync reset
  input wire logic BUSY, // Bus held off
  input wire logic NV_READ_STATE, // Read state
  input wire wsc_pkg::wsc_wipers_s WIPER, // Wipers
  input wire logic [511:0] TAP0, // Taps 0
  input wire logic [511:0] TAP1, // Taps 1
  input wire logic [127:0] TAP2, // Taps 2
  input wire logic BOTTOM_SW, // Bottom switch
  input wire logic [6:0] SLAVE_ADDR, // Slave address
  input wire logic [6:0] MEM_ADDR, // Store address
  input wire logic SLV_SEL_HI_PIN, // Pin
  input wire logic SLV_SEL_LO_PIN, // Pin
  input wire logic MEM_ADDR_HI_PIN, // Pin
  input wire logic MEM_ADDR_LO_PIN // Pin
);
  logic [2:0] up;
  logic [31:0] busy_n;
  // ==========
  // Helpers
  always_ff @(posedge MCLK) begin
    if (!RST_N) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  always_ff @(posedge MCLK) begin
    if (!RST_N || !BUSY) busy_n <= 32'h0;
    else busy_n <= busy_n + 32'h1;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // ==========
  // Assertions
  chk_bottom_on: assert property (BOTTOM_SW)
    else $error("bottom switch off");
  chk_tap_onehot: assert property (up >= 3'h3 |-> $onehot(TAP0) && $onehot(TAP1) && $onehot(TAP2))
    else $error("taps not one-hot");
  chk_tap_decode: assert property (up >= 3'h3 |->
      TAP0 == (512'h1 << $past(WIPER.w0)) && TAP1 == (512'h1 << $past(WIPER.w1))
      && TAP2 == (128'h1 << $past(WIPER.w2)))
    else $error("tap decode wrong");
  chk_slave_pins: assert property (
      (up == 3'h7 && $stable({SLV_SEL_HI_PIN, SLV_SEL_LO_PIN}))[*4]
      |-> SLAVE_ADDR == {5'h0A, SLV_SEL_HI_PIN, SLV_SEL_LO_PIN})
    else $error("slave address wrong");
  chk_mem_pins: assert property (
      (up == 3'h7 && $stable({MEM_ADDR_HI_PIN, MEM_ADDR_LO_PIN}))[*4]
      |-> MEM_ADDR == {5'h14, MEM_ADDR_HI_PIN, MEM_ADDR_LO_PIN})
    else $error("memory address wrong");
  chk_wiper_quiet: assert property (up >= 3'h2 && !$past(BUSY) |-> $stable(WIPER))
    else $error("wiper moved while idle");
  chk_nvread_exit: assert property (up >= 3'h2 && $fell(NV_READ_STATE) |-> $past(BUSY))
    else $error("read state left without command");
  chk_busy_bound: assert property (busy_n < STORE_CYCLES + 64)
    else $error("busy too long");
  // Short runs are plain commands or restore-all; a store holds off the full time
  chk_store_hold: assert property ($fell(BUSY) |->
      busy_n < 32'd8 || busy_n >= STORE_CYCLES)
    else $error("store hold-off too short");
  cover property ($rose(NV_READ_STATE));
  cover property (busy_n == STORE_CYCLES);
  cover property (WIPER.w0 == FULL9 && $past(WIPER.w0) == FULL9);
endmodule : wsc_unit_chk

//--- testbench/wsc_unit_tb.sv
// Self-checking bench for wsc_unit driven through the link-side master model.
// Assumes the checker and master model are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module wsc_unit_tb;
  import wsc_pkg::*;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic lrst_n = 1'b0;
  logic wp_n = 1'b1;
  logic wp_pull_n = 1'b1;
  logic [3:0] pins = 4'h0;
  logic cmd_valid, cmd_ready, busy, nv_rd;
  wsc_cmd_s cmd;
  wsc_wipers_s wiper, was;
  logic [6:0] slave_addr, mem_addr;
  int fail_count = 0;
  int n_compared = 0;
  always #4 mclk = ~mclk;
  always #15 lclk = ~lclk;
  wsc_unit #(.STORE_CYCLES(20)) u_dut (.MCLK(mclk), .RST_N(rst_n), .LCLK(lclk),
    .LRST_N(lrst_n), .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready),
    .WP_N_PIN(wp_n), .WP_PULL_N(wp_pull_n), .MEM_ADDR_HI_PIN(pins[3]),
    .MEM_ADDR_LO_PIN(pins[2]), .SLV_SEL_HI_PIN(pins[1]), .SLV_SEL_LO_PIN(pins[0]),
    .SLAVE_ADDR(slave_addr), .MEM_ADDR(mem_addr), .BUSY(busy), .NV_READ_STATE(nv_rd),
    .WIPER(wiper), .TAP0(), .TAP1(), .TAP2(), .BOTTOM_SW());
  wsc_master_model u_mst (.LCLK(lclk), .CMD_READY(cmd_ready), .BUSY(busy),
    .CMD_VALID(cmd_valid), .CMD(cmd));
  task automatic go(input logic [3:0] c, input logic [1:0] ch);
    u_mst.issue({1'b1, c, ch});
  endtask : go
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic t_steps;
    int i;
    go(WSC_INC6_ONE, 2'h0); `CHK(wiper, {9'h1FF, 9'h100, 7'h40})
    go(WSC_INC6_ONE, 2'h0); `CHK(wiper.w0, 9'h1FF)
    go(WSC_INC1_ONE, 2'h0); `CHK(wiper.w0, 9'h1FF)
    go(WSC_DEC6_ONE, 2'h0); `CHK(wiper, {9'h0FF, 9'h100, 7'h40})
    go(WSC_DEC6_ALL, 2'h3); `CHK(wiper, {9'h07F, 9'h080, 7'h20})
    go(WSC_INC1_ONE, 2'h1); `CHK(wiper, {9'h07F, 9'h081, 7'h20})
    go(WSC_DEC1_ALL, 2'h3); `CHK(wiper, {9'h07E, 9'h080, 7'h1F})
    go(WSC_INC1_ALL, 2'h3); `CHK(wiper, {9'h07F, 9'h081, 7'h20})
    for (i = 1; i <= 7; i++) begin
      go(WSC_DEC6_ONE, 2'h2); `CHK(wiper.w2, 7'(7'h20 >> i))
    end
    go(WSC_INC6_ONE, 2'h2); `CHK(wiper.w2, 7'h01)
    go(WSC_DEC1_ONE, 2'h2);
    go(WSC_DEC1_ONE, 2'h2); `CHK(wiper.w2, 7'h00)
    was = wiper;
    for (i = 12; i <= 15; i++) begin
      go(4'(i), 2'h0); `CHK(wiper, was)
    end
    u_mst.issue({1'b0, 4'(WSC_INC1_ALL), 2'h3}); `CHK(wiper, was)
    $display("test steps done");
  endtask : t_steps
  task automatic t_store;
    time t0;
    was = wiper;
    t0 = $time;
    go(WSC_STORE_ONE, 2'h0);
    // 20 store cycles of 8 ns at the least
    `CHK($time - t0 >= 64'd160, 1'b1)
    go(WSC_INC1_ONE, 2'h0);
    go(WSC_RESTORE_ONE, 2'h0); `CHK(wiper.w0, was.w0)
    `CHK(nv_rd, 1'b1)
    go(WSC_NOP, 2'h0); `CHK(nv_rd, 1'b0)
    @(posedge mclk);
    wp_n <= 1'b0;
    go(WSC_INC1_ONE, 2'h0); `CHK(wiper.w0, 9'(was.w0 + 9'h1))
    go(WSC_STORE_ONE, 2'h0);
    go(WSC_RESTORE_ONE, 2'h0); `CHK(wiper.w0, was.w0)
    go(WSC_NOP, 2'h0);
    // Pin released: the undriven sense alone must protect
    @(posedge mclk);
    wp_n <= 1'b1;
    wp_pull_n <= 1'b0;
    go(WSC_INC1_ONE, 2'h0);
    go(WSC_STORE_ONE, 2'h0);
    go(WSC_RESTORE_ONE, 2'h0); `CHK(wiper.w0, was.w0)
    go(WSC_NOP, 2'h0);
    go(WSC_RESTORE_ALL, 2'h3); `CHK(wiper, {was.w0, RST9, RST7})
    $display("test store done");
  endtask : t_store
  task automatic t_pins;
    int i;
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      pins <= {2'(i), 2'(3 - i)};
      repeat (6) @(posedge mclk);
      `CHK(slave_addr, {5'h0A, 2'(3 - i)})
      `CHK(mem_addr, {5'h14, 2'(i)})
    end
    $display("test pins done");
  endtask : t_pins
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge lclk);
    lrst_n <= 1'b1;
    @(posedge mclk);
    `CHK(wiper, {RST9, RST9, RST7})
    t_steps();
    t_store();
    t_pins();
    `CHK(u_mst.stalls, 0)
    close_out();
  end
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule : wsc_unit_tb
bind wsc_unit wsc_unit_chk #(.STORE_CYCLES(STORE_CYCLES)) u_chk (.MCLK, .RST_N, .BUSY,
  .NV_READ_STATE, .WIPER, .TAP0, .TAP1, .TAP2, .BOTTOM_SW, .SLAVE_ADDR, .MEM_ADDR,
  .SLV_SEL_HI_PIN, .SLV_SEL_LO_PIN, .MEM_ADDR_HI_PIN, .MEM_ADDR_LO_PIN);
